// ---- core/srp_pkg.sv ----
// Constants, types and timing figures shared by the soft reset sequencer.
// Assumes a 250 MHz core clock and a 32-bit Avalon-MM register port.
package srp_pkg;

  // Clock rate and derived timing counts.
  localparam int unsigned      CLK_MHZ      = 250;
  localparam int unsigned      REL_TIME_NS  = 400;
  localparam int unsigned      REL_CYC      = (REL_TIME_NS * CLK_MHZ) / 1000;
  localparam int unsigned      PRI_WAIT_US  = 1000;
  localparam longint unsigned  PRI_WAIT_CYC = longint'(PRI_WAIT_US) * longint'(CLK_MHZ);
  localparam longint unsigned  DIAG_TMO_S   = 31;
  localparam longint unsigned  DIAG_TMO_CYC = DIAG_TMO_S * longint'(CLK_MHZ) * 64'd1000000;
  localparam longint unsigned  SEC_DONE_S   = 30;
  localparam longint unsigned  SEC_DONE_CYC = SEC_DONE_S * longint'(CLK_MHZ) * 64'd1000000;
  localparam int unsigned      TMR_W        = 36;

  // Register byte offsets.
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_STATUS = 5'h04;
  localparam logic [4:0] OFF_ERROR  = 5'h08;
  localparam logic [4:0] OFF_DEVICE = 5'h0c;
  localparam logic [4:0] OFF_SIG    = 5'h10;
  localparam logic [4:0] OFF_CMD    = 5'h14;
  localparam logic [4:0] OFF_CONFIG = 5'h18;
  localparam logic [4:0] OFF_MODE   = 5'h1c;

  // Field positions.
  localparam int unsigned CTRL_SOFT_RESET_BIT_BIT = 2;
  localparam int unsigned STAT_BUSY_BIT = 7;
  localparam int unsigned STAT_DRQ_BIT  = 3;
  localparam int unsigned DEV_SEL_BIT   = 4;
  localparam int unsigned CFG_FAIL_BIT  = 0;
  localparam int unsigned CFG_UDMA_BIT  = 1;
  localparam int unsigned CFG_ROLE_BIT  = 2;
  localparam int unsigned CFG_SEEN_BIT  = 3;
  localparam int unsigned MODE_SAVE_BIT = 31;

  // Values and masks.
  localparam logic [6:0] STAT_CLR_ATA    = 7'h0d;
  localparam logic [6:0] STAT_CLR_PKT    = 7'h7d;
  localparam logic [7:0] CMD_DEVICE_RST  = 8'h08;
  localparam logic [6:0] DIAG_PASS_CODE  = 7'h01;
  localparam logic [6:0] DIAG_FAIL_CODE  = 7'h02;
  localparam logic [7:0] MODE_DEFAULT    = 8'h00;
  localparam logic [7:0] STAT_RESET      = 8'h00;
  localparam logic [7:0] DEV_RESET       = 8'h00;

  // Pin index inside the synchroniser vector.
  localparam int unsigned PIN_HWRST_N   = 0;
  localparam int unsigned PIN_DIAG_N    = 1;
  localparam int unsigned PIN_PRESENT_N = 2;
  localparam int unsigned PIN_ROLE      = 3;
  localparam int unsigned PIN_NUM       = 4;

  typedef struct packed {
    logic        read;
    logic        write;
    logic [4:0]  address;
    logic [31:0] writedata;
    logic [3:0]  byteenable;
  } srp_avreq_t;

  typedef enum logic [2:0] {
    SRP_IDLE                    = 3'b000,
    SRP_ASSERT                  = 3'b001,
    SRP_PRIMARY_WAIT_STATE      = 3'b010,
    SRP_PRIMARY_SAMPLE          = 3'b011,
    SRP_SECONDARY_RELEASE_STATE = 3'b100,
    SRP_SET_STATUS              = 3'b101,
    SRP_HW_RESET                = 3'b110
  } srp_state_t;

endpackage : srp_pkg

// ---- core/srp_seq.sv ----
// Drive-side soft reset sequencer with its Avalon-MM register file.
// Assumes bus pins are asynchronous, the pad logic tristates the data and
// request pins from o_bus_release, and the hardware reset flow runs elsewhere.
`timescale 1ns/1ps
`default_nettype none
module srp_seq
  import srp_pkg::*;
#(
  parameter bit          HAS_PACKET  = 1'b0,
  parameter longint      WAIT_CYC    = PRI_WAIT_CYC,
  parameter longint      TMO_CYC     = DIAG_TMO_CYC,
  parameter longint      SELF_CYC    = 64'd1000,
  parameter logic [31:0] SIGNATURE   = 32'h0000_0101
)(
  // Clock and reset.
  input  wire logic        i_clk,
  input  wire logic        i_resetn,
  // Avalon-MM slave.
  input  wire logic [4:0]  i_avs_address,
  input  wire logic        i_avs_read,
  input  wire logic        i_avs_write,
  input  wire logic [31:0] i_avs_writedata,
  input  wire logic [3:0]  i_avs_byteenable,
  output logic [31:0]      o_avs_readdata,
  output logic             o_avs_waitrequest,
  // Drive bus pins.
  input  wire logic        i_hw_reset_n,
  input  wire logic        i_diag_pass_line_n,
  output logic             o_diag_pass_line_n,
  output logic             o_diag_pass_line_oe,
  input  wire logic        i_drive_present_line_n,
  input  wire logic        i_secondary_strap,
  // Status towards the rest of the drive.
  output logic             o_bus_release,
  output logic             o_busy,
  output logic             o_bus_idle,
  output logic             o_defaults_revert,
  output logic             o_hw_reset_run,
  output logic             o_device_reset_cmd
);

  localparam int CHK_REL = REL_CYC;
  // Idle pin levels: reset, pass and presence lines high, role strap low (primary).
  localparam logic [PIN_NUM-1:0] SYNC_IDLE = 4'h7;

  srp_avreq_t           req;
  srp_state_t           state_q, state_d;
  logic [PIN_NUM-1:0]   sync1_q, sync2_q;
  logic                 soft_reset_bit_q, soft_reset_bit_prev_q, busy_q, err7_q, dev_sel_q;
  logic [6:0]           err_code_q, stat_q;
  logic                 waitreq_q, fail_q, udma_q, role_q, seen_q;
  logic                 oe_q, release_q, idle_q, revert_q, devrst_q, hwrun_q;
  logic [7:0]           mode_q, saved_mode_q;
  logic                 saved_valid_q;
  logic [31:0]          rdata_q;
  logic [TMR_W-1:0]     clr_cnt, st_cnt;

  assign req = '{read: i_avs_read, write: i_avs_write, address: i_avs_address,
                 writedata: i_avs_writedata, byteenable: i_avs_byteenable};

  // Pin synchronisers; only the second stage is read.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      sync1_q <= SYNC_IDLE;
      sync2_q <= SYNC_IDLE;
    end
    else
    begin
      sync1_q <= {i_secondary_strap, i_drive_present_line_n, i_diag_pass_line_n, i_hw_reset_n};
      sync2_q <= sync1_q;
    end
  end

  wire hw_rst     = !sync2_q[PIN_HWRST_N];
  wire diag_seen  = !sync2_q[PIN_DIAG_N];
  wire present    = !sync2_q[PIN_PRESENT_N];
  wire acc        = (req.read || req.write) && !waitreq_q;
  wire wr_lo      = acc && req.write && req.byteenable[0];
  wire wr_ctrl    = wr_lo && (req.address == OFF_CTRL);
  wire wr_stat    = wr_lo && (req.address == OFF_STATUS);
  wire wr_dev     = wr_lo && (req.address == OFF_DEVICE);
  wire wr_cmd     = wr_lo && (req.address == OFF_CMD);
  wire wr_cfg     = wr_lo && (req.address == OFF_CONFIG);
  wire wr_mode    = wr_lo && (req.address == OFF_MODE);
  wire wr_save    = wr_mode && req.byteenable[3] && req.writedata[MODE_SAVE_BIT];
  wire soft_reset_bit_rise  = soft_reset_bit_q && !soft_reset_bit_prev_q;
  wire quiet      = !hw_rst && !soft_reset_bit_rise;
  wire in_seq     = (state_q != SRP_IDLE);
  wire wait_done  = {28'h0, clr_cnt} >= (WAIT_CYC - 64'd1);
  wire diag_tmo   = {28'h0, clr_cnt} >= (TMO_CYC - 64'd1);
  wire self_done  = {28'h0, st_cnt} >= SELF_CYC;
  wire fin        = quiet && (state_q == SRP_SET_STATUS) && self_done;
  wire sample_out = quiet && (state_q == SRP_PRIMARY_SAMPLE) && (diag_seen || diag_tmo);
  wire skip_wait  = quiet && (state_q == SRP_ASSERT) && !soft_reset_bit_q && !role_q && !seen_q;
  wire [6:0] clr_mask  = HAS_PACKET ? STAT_CLR_PKT : STAT_CLR_ATA;
  wire [7:0] mode_init = saved_valid_q ? saved_mode_q : MODE_DEFAULT;
  wire sel_clear  = (state_d == SRP_PRIMARY_WAIT_STATE) || (state_d == SRP_SECONDARY_RELEASE_STATE) ||
                    (state_d == SRP_SET_STATUS);
  wire busy_d     = soft_reset_bit_rise ? 1'b1 : (fin ? 1'b0 : busy_q);
  wire drq_d      = fin ? 1'b0 : (wr_stat ? req.writedata[STAT_DRQ_BIT] : stat_q[STAT_DRQ_BIT]);

  // Sequence timers counted in core clock cycles.
  srp_timer #(.W(TMR_W)) u_clr_tmr (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (state_q == SRP_ASSERT),
    .o_count  (clr_cnt)
  );

  srp_timer #(.W(TMR_W)) u_self_tmr (
    .i_clk    (i_clk),
    .i_resetn (i_resetn),
    .i_clear  (soft_reset_bit_rise || hw_rst),
    .o_count  (st_cnt)
  );

  // Next state; a hardware reset and a fresh soft bit outrank everything.
  always_comb
  begin
    state_d = state_q;
    if (hw_rst)
      state_d = SRP_HW_RESET;
    else if (soft_reset_bit_rise)
      state_d = SRP_ASSERT;
    else
    begin
      case (state_q)
        SRP_IDLE:                    state_d = SRP_IDLE;
        SRP_HW_RESET:                state_d = SRP_IDLE;
        SRP_ASSERT:
          if (!soft_reset_bit_q)
            state_d = role_q ? SRP_SECONDARY_RELEASE_STATE :
                      (seen_q ? SRP_PRIMARY_WAIT_STATE : SRP_SET_STATUS);
        SRP_PRIMARY_WAIT_STATE:
          if (wait_done)
            state_d = SRP_PRIMARY_SAMPLE;
        SRP_PRIMARY_SAMPLE:
          if (diag_seen || diag_tmo)
            state_d = SRP_SET_STATUS;
        SRP_SECONDARY_RELEASE_STATE: state_d = SRP_SET_STATUS;
        SRP_SET_STATUS:
          if (self_done)
            state_d = SRP_IDLE;
        default:                     state_d = SRP_IDLE;
      endcase
    end
  end

  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      state_q <= SRP_IDLE;
    else
      state_q <= state_d;
  end

  // Soft bit, role strap followed between sequences, and presence seen at the last hardware reset.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      soft_reset_bit_q      <= 1'b0;
      soft_reset_bit_prev_q <= 1'b0;
      role_q      <= 1'b0;
      seen_q      <= 1'b0;
    end
    else
    begin
      soft_reset_bit_q      <= wr_ctrl ? req.writedata[CTRL_SOFT_RESET_BIT_BIT] : soft_reset_bit_q;
      soft_reset_bit_prev_q <= soft_reset_bit_q;
      // The strap is followed only between sequences, so a running one never changes role.
      role_q      <= (state_q == SRP_IDLE || state_q == SRP_HW_RESET) ? sync2_q[PIN_ROLE] : role_q;
      seen_q      <= (hw_rst && state_q != SRP_HW_RESET) ? 1'b0 :
                     ((state_q == SRP_HW_RESET) ? (seen_q || present) : seen_q);
    end
  end

  // Status, error and select bits; the Features register is left alone.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      busy_q     <= 1'b0;
      stat_q     <= STAT_RESET[6:0];
      err7_q     <= 1'b0;
      err_code_q <= '0;
      dev_sel_q  <= 1'b0;
    end
    else
    begin
      busy_q     <= busy_d;
      stat_q     <= fin ? (stat_q & ~clr_mask) :
                    (wr_stat ? req.writedata[6:0] : stat_q);
      err7_q     <= skip_wait ? 1'b0 : (sample_out ? !diag_seen :
                    ((fin && role_q) ? 1'b0 : err7_q));
      err_code_q <= fin ? (fail_q ? DIAG_FAIL_CODE : DIAG_PASS_CODE) : err_code_q;
      dev_sel_q  <= sel_clear ? 1'b0 :
                    (wr_dev ? req.writedata[DEV_SEL_BIT] : dev_sel_q);
    end
  end

  // Pass line, bus release and settings; all but the mode (reloaded at set-status in packet builds) held across the sequence.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      oe_q          <= 1'b0;
      release_q     <= 1'b0;
      revert_q      <= 1'b0;
      fail_q        <= 1'b0;
      udma_q        <= 1'b0;
      mode_q        <= MODE_DEFAULT;
      saved_mode_q  <= MODE_DEFAULT;
      saved_valid_q <= 1'b0;
    end
    else
    begin
      oe_q          <= (hw_rst || (soft_reset_bit_rise && !role_q) ||
                        (state_d == SRP_SECONDARY_RELEASE_STATE)) ? 1'b0 :
                       ((fin && role_q) ? !fail_q : oe_q);
      release_q     <= (soft_reset_bit_rise || hw_rst) ? 1'b1 : (fin ? 1'b0 : release_q);
      revert_q      <= soft_reset_bit_rise && !hw_rst && !HAS_PACKET;
      fail_q        <= wr_cfg ? req.writedata[CFG_FAIL_BIT] : fail_q;
      udma_q        <= wr_cfg ? req.writedata[CFG_UDMA_BIT] : udma_q;
      mode_q        <= (fin && HAS_PACKET) ? mode_init :
                       (wr_mode ? req.writedata[7:0] : mode_q);
      saved_mode_q  <= wr_save ? req.writedata[7:0] : saved_mode_q;
      saved_valid_q <= saved_valid_q || wr_save;
    end
  end

  // Register read mux; unmapped offsets read as zero.
  wire [31:0] rd_word =
    (req.address == OFF_CTRL)   ? {29'h0, soft_reset_bit_q, 2'h0} :
    (req.address == OFF_STATUS) ? {24'h0, busy_q, stat_q} :
    (req.address == OFF_ERROR)  ? {24'h0, err7_q, err_code_q} :
    (req.address == OFF_DEVICE) ? {27'h0, dev_sel_q, 4'h0} :
    (req.address == OFF_SIG)    ? SIGNATURE :
    (req.address == OFF_CONFIG) ? {28'h0, seen_q, role_q, udma_q, fail_q} :
    (req.address == OFF_MODE)   ? {saved_valid_q, 23'h0, mode_q} : 32'h0;

  // One wait cycle per access keeps the read mux off the output path.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      waitreq_q <= 1'b1;
      rdata_q   <= '0;
      idle_q    <= 1'b1;
      devrst_q  <= 1'b0;
      hwrun_q   <= 1'b0;
    end
    else
    begin
      waitreq_q <= !((req.read || req.write) && waitreq_q);
      rdata_q   <= (req.read && waitreq_q) ? rd_word : rdata_q;
      idle_q    <= !busy_d && !drq_d;
      devrst_q  <= wr_cmd && (req.writedata[7:0] == CMD_DEVICE_RST) && !in_seq;
      hwrun_q   <= (state_d == SRP_HW_RESET);
    end
  end

  assign o_avs_readdata      = rdata_q;
  assign o_avs_waitrequest   = waitreq_q;
  assign o_diag_pass_line_n  = 1'b0;
  assign o_diag_pass_line_oe = oe_q;
  assign o_bus_release       = release_q;
  assign o_busy              = busy_q;
  assign o_bus_idle          = idle_q;
  assign o_defaults_revert   = revert_q;
  assign o_hw_reset_run      = hwrun_q;
  assign o_device_reset_cmd  = devrst_q;

  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);

  sequence s_sec_done;
    fin && role_q;
  endsequence

  sequence s_sec_report;
    !busy_q ##0 (oe_q == !fail_q) ##0 !o_bus_release;
  endsequence

  chk_set_busy_release: assert property (soft_reset_bit_rise && !hw_rst |-> ##[1:CHK_REL] (busy_q && release_q))
    else $error("busy or release missing after soft bit set");
  chk_hw_abandon: assert property (hw_rst |=> (state_q == SRP_HW_RESET) && (st_cnt == '0))
    else $error("hardware reset did not abandon sequence");
  chk_restart_seq: assert property (soft_reset_bit_rise && !hw_rst |=> (state_q == SRP_ASSERT) && (st_cnt == 0))
    else $error("soft bit set did not restart sequence");
  chk_cmd_ignored: assert property (wr_cmd && in_seq |=> !o_device_reset_cmd)
    else $error("device reset command acted on mid-sequence");
  chk_skip_wait: assert property (skip_wait |=> (state_q == SRP_SET_STATUS) && !err7_q)
    else $error("primary waited with no secondary present");
  chk_wait_bound: assert property ($rose(state_q == SRP_PRIMARY_SAMPLE) |-> wait_done && !dev_sel_q)
    else $error("primary sampled pass line too early");
  chk_diag_result: assert property (sample_out |=> (state_q == SRP_SET_STATUS) && (err7_q == !$past(diag_seen)))
    else $error("pass line sample gave wrong error bit");
  chk_sec_release: assert property (state_q == SRP_SECONDARY_RELEASE_STATE |-> !oe_q && !dev_sel_q)
    else $error("secondary did not release pass line");
  chk_sec_report: assert property (s_sec_done |=> s_sec_report)
    else $error("secondary result not reported on pass line");
  chk_status_clear: assert property (fin |=> ((stat_q & clr_mask) == 7'h0) && !busy_q)
    else $error("status bits not cleared at set-status");
  chk_bus_idle: assert property (o_bus_idle == (!busy_q && !stat_q[STAT_DRQ_BIT]))
    else $error("bus idle flag disagrees with busy and request");

endmodule : srp_seq
`default_nettype wire

// ---- core/srp_timer.sv ----
// Saturating elapsed-time counter for the soft reset sequencer.
// Assumes the caller clears it synchronously on the event it measures from.
`timescale 1ns/1ps
`default_nettype none
module srp_timer
  import srp_pkg::*;
#(
  parameter int unsigned W = TMR_W
)(
  // Clock and reset.
  input  wire logic         i_clk,
  input  wire logic         i_resetn,
  // Control.
  input  wire logic         i_clear,
  // Count.
  output logic [W-1:0]      o_count
);

  logic [W-1:0] cnt_q;
  wire          at_top = &cnt_q;
  wire [W-1:0]  cnt_d  = i_clear ? '0 : (at_top ? cnt_q : cnt_q + 1'b1);

  // Saturation keeps a long-stalled sequence from wrapping into a short time.
  always_ff @(posedge i_clk)
  begin
    if (!i_resetn)
      cnt_q <= '0;
    else
      cnt_q <= cnt_d;
  end

  assign o_count = cnt_q;

endmodule : srp_timer
`default_nettype wire

// ---- dv/soft_reset_protocol_tb.sv ----
// Self-checking bench for the soft reset sequencer, acting as host.
// Assumes srp_pkg and the bus partner model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module soft_reset_protocol_tb
  import srp_pkg::*;
;
  // Host hold time of 5 us; the 2 ms poll delay is scaled like the drive timers.
  localparam int HOLD_CYC = 1250;
  localparam int POLL_CYC = 60;
  typedef struct packed {logic wr; logic [4:0] addr; logic [31:0] wdata; logic [31:0] exp;} srp_row_t;
  logic        i_clk, i_resetn, avs_read, avs_write, hw_rst_req, peer_present, peer_pass, strap;
  logic [4:0]  avs_address;
  logic [31:0] avs_writedata, avs_readdata, rdata;
  logic        avs_waitrequest, pass_in_n, pass_out_n, pass_oe, present_n, hw_reset_n;
  logic        bus_release, busy, bus_idle, revert, hw_run, dev_rst;
  int          fail_count, tests_run, i;
  int          rst_pulses = 0;
  int          rev_pulses = 0;
  srp_row_t    rows [6] = '{'{1'b0, OFF_CTRL, 32'h0, 32'h0}, '{1'b1, OFF_SIG, 32'hffff_ffff, 32'h0000_0101},
    '{1'b1, OFF_DEVICE, 32'h10, 32'h10}, '{1'b1, OFF_CONFIG, 32'h2, 32'h2},
    '{1'b1, 5'h06, 32'hff, 32'h0}, '{1'b1, OFF_STATUS, 32'h0d, 32'h0d}};

  srp_seq #(.WAIT_CYC(20), .TMO_CYC(200), .SELF_CYC(30)) i_dut (
    .i_clk(i_clk), .i_resetn(i_resetn), .i_avs_address(avs_address), .i_avs_read(avs_read),
    .i_avs_write(avs_write), .i_avs_writedata(avs_writedata), .i_avs_byteenable(4'hf),
    .o_avs_readdata(avs_readdata), .o_avs_waitrequest(avs_waitrequest), .i_hw_reset_n(hw_reset_n),
    .i_diag_pass_line_n(pass_in_n), .o_diag_pass_line_n(pass_out_n), .o_diag_pass_line_oe(pass_oe),
    .i_drive_present_line_n(present_n), .i_secondary_strap(strap), .o_bus_release(bus_release),
    .o_busy(busy), .o_bus_idle(bus_idle), .o_defaults_revert(revert), .o_hw_reset_run(hw_run),
    .o_device_reset_cmd(dev_rst));
  srp_bus_model i_bus (
    .i_hw_rst_req(hw_rst_req), .i_peer_present(peer_present), .i_peer_pass(peer_pass),
    .i_dut_pass_oe(pass_oe), .i_dut_pass_n(pass_out_n), .o_hw_reset_n(hw_reset_n), .o_present_n(present_n),
    .o_pass_n(pass_in_n));

  initial
  begin
    i_clk = 1'b0;
    forever #2 i_clk = ~i_clk;
  end
  always @(posedge i_clk)
  begin
    if (dev_rst === 1'b1)
      rst_pulses <= rst_pulses + 1;
    if (revert === 1'b1)
      rev_pulses <= rev_pulses + 1;
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    tests_run++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("ERROR %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  // Request held until waitrequest is sampled low; released only after that edge.
  task automatic av_xfer(input logic wr, input logic [4:0] a, input logic [31:0] d, output logic [31:0] q);
    @(posedge i_clk);
    avs_address   <= a;
    avs_writedata <= d;
    avs_write     <= wr;
    avs_read      <= !wr;
    do @(posedge i_clk); while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
  endtask : av_xfer

  task automatic av_wr(input logic [4:0] a, input logic [31:0] d);
    logic [31:0] unused;
    av_xfer(1'b1, a, d, unused);
  endtask : av_wr

  // Sets the soft bit and holds it for the minimum time before clearing it.
  task automatic soft_cycle();
    av_wr(OFF_CTRL, 32'h4);
    repeat (3) @(posedge i_clk);
    check(busy, 32'h1, "busy after set");
    check(bus_release, 32'h1, "bus released");
    check(pass_oe, 32'h0, "pass line released");
    check(bus_idle, 32'h0, "idle while busy");
    // A device reset command while the bit is held must be ignored.
    av_wr(OFF_CMD, {24'h0, CMD_DEVICE_RST});
    repeat (HOLD_CYC) @(posedge i_clk);
    av_wr(OFF_CTRL, 32'h0);
  endtask : soft_cycle

  // Host polls status until busy clears, then reads the error register.
  task automatic wait_ready(input logic [31:0] err_exp);
    int n;
    repeat (POLL_CYC) @(posedge i_clk);
    rdata = 32'h80;
    for (n = 0; n < 400 && rdata[STAT_BUSY_BIT] !== 1'b0; n++)
      av_xfer(1'b0, OFF_STATUS, 32'h0, rdata);
    check(rdata, 32'h0, "status after sequence");
    av_xfer(1'b0, OFF_ERROR, 32'h0, rdata);
    check(rdata, err_exp, "error register");
    av_xfer(1'b0, OFF_DEVICE, 32'h0, rdata);
    check(rdata, 32'h0, "select cleared");
  endtask : wait_ready

  task automatic conclude();
    $display("Checks run %0d, mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : conclude

  initial
  begin
    #120000;
    fail_count++;
    $display("ERROR %0t: watchdog expired", $time);
    conclude();
  end

  initial
  begin
    {avs_read, avs_write, hw_rst_req, peer_present, peer_pass} = 5'h00;
    strap         = 1'b0;
    avs_address   = 5'h00;
    avs_writedata = 32'h0;
    i_resetn      = 1'b0;
    repeat (12) @(posedge i_clk);
    i_resetn <= 1'b1;
    repeat (3) @(posedge i_clk);
    check(busy, 32'h0, "busy after reset");
    check(bus_idle, 32'h1, "idle after reset");
    check(bus_release, 32'h0, "bus held after reset");
    for (i = 0; i < 6; i++)
    begin
      if (rows[i].wr)
        av_wr(rows[i].addr, rows[i].wdata);
      av_xfer(1'b0, rows[i].addr, 32'h0, rdata);
      check(rdata, rows[i].exp, "register row");
    end
    check(bus_idle, 32'h0, "request flag blocks idle");
    // No secondary seen: straight to set-status, command ignored meanwhile.
    soft_cycle();
    wait_ready(32'h01);
    av_xfer(1'b0, OFF_CONFIG, 32'h0, rdata);
    check(rdata, 32'h2, "ultra dma kept");
    check(rst_pulses, 32'h0, "command ignored");
    check(rev_pulses, 32'h1, "defaults revert pulse");
    check(bus_idle, 32'h1, "bus idle");
    av_wr(OFF_CMD, {24'h0, CMD_DEVICE_RST});
    repeat (2) @(posedge i_clk);
    check(rst_pulses, 32'h1, "command taken when idle");
    // Hardware reset mid-sequence with the secondary present.
    repeat (HOLD_CYC) @(posedge i_clk);
    av_wr(OFF_CTRL, 32'h4);
    repeat (10) @(posedge i_clk);
    hw_rst_req   <= 1'b1;
    peer_present <= 1'b1;
    repeat (4) @(posedge i_clk);
    check(hw_run, 32'h1, "hardware reset runs");
    hw_rst_req <= 1'b0;
    repeat (HOLD_CYC) @(posedge i_clk);
    av_wr(OFF_CTRL, 32'h0);
    av_xfer(1'b0, OFF_CONFIG, 32'h0, rdata);
    check(rdata & 32'h8, 32'h8, "presence seen");
    repeat (HOLD_CYC) @(posedge i_clk);
    // Silent secondary: primary waits the whole timeout then flags failure.
    soft_cycle();
    repeat (150) @(posedge i_clk);
    check(busy, 32'h1, "busy before timeout");
    wait_ready(32'h81);
    repeat (HOLD_CYC) @(posedge i_clk);
    // Secondary passes early; primary must still wait its minimum.
    soft_cycle();
    peer_pass <= 1'b1;
    repeat (14) @(posedge i_clk);
    check(busy, 32'h1, "minimum wait kept");
    wait_ready(32'h01);
    // Secondary strap: a failed and then a passed self-test on the pass line.
    strap     <= 1'b1;
    peer_pass <= 1'b0;
    av_wr(OFF_CONFIG, 32'h3);
    repeat (HOLD_CYC) @(posedge i_clk);
    soft_cycle();
    wait_ready(32'h02);
    check(pass_oe, 32'h0, "pass line left negated");
    av_wr(OFF_CONFIG, 32'h2);
    repeat (HOLD_CYC) @(posedge i_clk);
    soft_cycle();
    wait_ready(32'h01);
    check(pass_oe, 32'h1, "pass line asserted");
    check(pass_out_n, 32'h0, "pass line driven low");
    conclude();
  end
endmodule : soft_reset_protocol_tb
`default_nettype wire

// ---- dv/srp_bus_model.sv ----
// Drive-bus partner: reset pin, presence and pass lines seen by one drive.
// Assumes bench requests change just after a rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module srp_bus_model (
  // Requests from the bench.
  input  wire logic i_hw_rst_req,
  input  wire logic i_peer_present,
  input  wire logic i_peer_pass,
  // Drive under test.
  input  wire logic i_dut_pass_oe,
  input  wire logic i_dut_pass_n,
  // Resolved lines.
  output logic      o_hw_reset_n,
  output logic      o_present_n,
  output logic      o_pass_n
);
  // Shared lines have pull-ups, so a released line reads high, not its last value.
  assign o_hw_reset_n = !i_hw_rst_req;
  assign o_present_n  = !i_peer_present;
  assign o_pass_n     = !((i_dut_pass_oe && !i_dut_pass_n) || i_peer_pass);
endmodule : srp_bus_model
`default_nettype wire
